// ### wcs_cycle_stealer.sv
`timescale 1ns/1ps
`include "wcs_cfg.svh"

// Contract
// - Serial 0 steals only with continuous transfer enabled
// - Serial 4: one steal per byte request
// - USB packet: one steal per byte request
// - Audio: two or three steals per channel
// - Steal stalls CPU and moves the RAM data
// - Timers and peripherals keep running during steals
// - No new grants in halt or deep standby; an audio burst already granted still finishes its steals
// - Each steal delays the program by one cycle; code keeps the CPU stalled while a full buffer pauses an audio burst
module wcs_cycle_stealer
    import wcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic halt_mode,
    input wire logic hold_mode,
    input wire logic continuous_transfer_enable,
    input wire logic audio_three_words,
    input wire logic [3:0] req_valid,
    input wire wcs_req_s [3:0] req_info,
    output logic [3:0] req_grant_q,
    output logic cpu_wait_q,
    output logic ram_en_q,
    output logic ram_we_q,
    output wcs_addr_t ram_addr_q,
    output wcs_byte_t ram_wdata_q,
    input wire wcs_byte_t ram_rdata,
    output logic rd_valid_q,
    output wcs_rd_s rd_word_q,
    input wire logic rd_ready
);

    // Lowest set index wins
    function automatic wcs_src_t pick_first(input logic [3:0] vec);
        wcs_src_t idx;
        idx = `WCS_SRC_AUDIO;
        for (int i = `WCS_NUM_SRC - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = wcs_src_t'(i);
            end
        end
        return idx;
    endfunction

    wcs_state_e state_q, state_d; // Arbiter state
    logic [3:0] gnt_d; // Next grant pulses
    logic cpu_wait_d; // Next stall level
    logic ram_en_d; // Next RAM strobe
    logic ram_we_d; // Next RAM direction
    wcs_addr_t addr_d; // Next RAM address
    wcs_byte_t wdata_d; // Next write byte
    wcs_src_t src_q, src_d; // Owner of the cycle on the RAM port
    logic [1:0] left_q, left_d; // Audio words still owed
    logic three_q, three_d; // Audio burst length latched at grant
    logic [3:0] eff; // Requests eligible this cycle
    wcs_src_t win; // Winning slot
    logic free; // Arbiter may start a new steal
    logic aud_go; // Audio burst advances this cycle
    logic low_power; // Halt or deep standby
    logic rd_pend_q; // Read data lands on ram_rdata now
    wcs_src_t rd_src_q; // Owner of that read
    logic push, pop; // Return buffer transfers
    logic [2:0] occ_n; // Buffer fill after this edge
    logic room; // Space reserved for one more read
    logic v1_q; // Second buffer slot holds a word
    wcs_rd_s e1_q; // Second buffer slot

    assign low_power = halt_mode | hold_mode;

    // Return buffer accounting; reads in flight are counted so none can overflow
    assign push = rd_pend_q;
    assign pop = rd_valid_q & rd_ready;
    assign occ_n = 3'(rd_valid_q) + 3'(v1_q) + 3'(push) - 3'(pop);
    assign room = (occ_n + 3'(ram_en_q & ~ram_we_q)) < `WCS_BUF_DEPTH;

    // Eligible requests per slot
    genvar g;
    generate
        for (g = 0; g < `WCS_NUM_SRC; g++) begin : g_elig
            if (g == 0) begin : g_serial_channel_0
                // Only continuous mode with the enable bit asks for RAM
                assign eff[g] = req_valid[g] & continuous_transfer_enable
                    & ~req_grant_q[g] & ~low_power
                    & (req_info[g].write | room);
            end else begin : g_other
                // A slot granted last cycle is still dropping its request
                assign eff[g] = req_valid[g] & ~req_grant_q[g]
                    & ~low_power
                    & (req_info[g].write | room);
            end
        end
    endgenerate

    assign win = pick_first(eff);

    // Next-state decode of the arbiter
    always_comb begin
        state_d = state_q;
        gnt_d = 4'h0;
        cpu_wait_d = 1'b0;
        ram_en_d = 1'b0;
        ram_we_d = ram_we_q;
        addr_d = ram_addr_q;
        wdata_d = ram_wdata_q;
        src_d = src_q;
        left_d = left_q;
        three_d = three_q;
        free = 1'b0;
        aud_go = 1'b0;
        unique case (state_q)
            ST_IDLE, ST_STEAL: begin
                free = 1'b1;
            end
            ST_AUDIO: begin
                if (left_q == `WCS_RST_LEFT) begin
                    // Last word on the port now, next steal may follow
                    free = 1'b1;
                end else begin
                    // Stall holds even while a full buffer pauses the burst
                    cpu_wait_d = 1'b1;
                    aud_go = ram_we_q | room;
                    if (aud_go) begin
                        ram_en_d = 1'b1;
                        addr_d = ram_addr_q + 16'h0001;
                        wdata_d = req_info[`WCS_SRC_AUDIO].wdata;
                        left_d = left_q - 2'h1;
                    end
                end
            end
            default: begin
                // Illegal code recovers through idle
                free = 1'b1;
            end
        endcase
        if (free) begin
            state_d = ST_IDLE;
            if (|eff) begin
                // One stolen cycle: CPU stalls while RAM serves the peripheral
                gnt_d[win] = 1'b1;
                cpu_wait_d = 1'b1;
                ram_en_d = 1'b1;
                ram_we_d = req_info[win].write;
                addr_d = req_info[win].addr;
                wdata_d = req_info[win].wdata;
                src_d = win;
                if (win == `WCS_SRC_AUDIO) begin
                    state_d = ST_AUDIO;
                    three_d = audio_three_words;
                    left_d = audio_three_words ? `WCS_AUDIO_LEFT_THREE
                                               : `WCS_AUDIO_LEFT_TWO;
                end else begin
                    // Serial and USB take exactly one cycle per request
                    state_d = ST_STEAL;
                    left_d = `WCS_RST_LEFT;
                end
            end
        end
    end

    // Arbiter state and RAM port registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            req_grant_q <= 4'h0;
            ram_en_q <= 1'b0;
            ram_we_q <= 1'b0;
            ram_addr_q <= `WCS_RST_ADDR;
            ram_wdata_q <= `WCS_RST_BYTE;
            src_q <= `WCS_SRC_SER0;
            left_q <= `WCS_RST_LEFT;
            three_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_grant_q <= gnt_d;
            ram_en_q <= ram_en_d;
            ram_we_q <= ram_we_d;
            ram_addr_q <= addr_d;
            ram_wdata_q <= wdata_d;
            src_q <= src_d;
            left_q <= left_d;
            three_q <= three_d;
        end
    end

    // CPU stall; only the sequencer is held, no clock is gated
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cpu_wait_q <= 1'b0;
        end else begin
            cpu_wait_q <= cpu_wait_d;
        end
    end

    // Synchronous RAM answers one cycle after the strobe
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_pend_q <= 1'b0;
            rd_src_q <= `WCS_SRC_SER0;
        end else begin
            rd_pend_q <= ram_en_q & ~ram_we_q;
            rd_src_q <= src_q;
        end
    end

    // Two-entry return buffer; head slot drives the outputs directly
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
            rd_word_q <= '0;
            v1_q <= 1'b0;
            e1_q <= '0;
        end else begin
            if (push && pop) begin
                if (v1_q) begin
                    rd_word_q <= e1_q;
                    e1_q <= '{src: rd_src_q, data: ram_rdata};
                end else begin
                    rd_word_q <= '{src: rd_src_q, data: ram_rdata};
                end
            end else if (pop) begin
                // Head drains, second word moves up
                rd_word_q <= e1_q;
                rd_valid_q <= v1_q;
                v1_q <= 1'b0;
            end else if (push) begin
                if (!rd_valid_q) begin
                    rd_word_q <= '{src: rd_src_q, data: ram_rdata};
                    rd_valid_q <= 1'b1;
                end else begin
                    e1_q <= '{src: rd_src_q, data: ram_rdata};
                    v1_q <= 1'b1;
                end
            end
        end
    end

    // Checks on the arbiter and buffer
    serial0_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
        !continuous_transfer_enable |=> !req_grant_q[0])
        else $error("serial 0 granted without continuous enable");

    serial4_single_a: assert property (@(posedge clk_sys) disable iff (reset)
        req_grant_q[1] |-> cpu_wait_q && ram_en_q ##1 !req_grant_q[1])
        else $error("serial 4 steal not a single cycle");

    usb_single_a: assert property (@(posedge clk_sys) disable iff (reset)
        req_grant_q[2] |-> state_q == ST_STEAL && src_q == `WCS_SRC_USB)
        else $error("usb steal not recorded as single steal");

    audio_len_a: assert property (@(posedge clk_sys) disable iff (reset)
        req_grant_q[3] |-> state_q == ST_AUDIO
            && left_q == (three_q ? `WCS_AUDIO_LEFT_THREE : `WCS_AUDIO_LEFT_TWO))
        else $error("audio burst length wrong");

    audio_step_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == ST_AUDIO && left_q != 2'h0 && aud_go)
            |=> ram_en_q && cpu_wait_q && left_q == $past(left_q) - 2'h1)
        else $error("audio burst did not advance");

    steal_stalls_a: assert property (@(posedge clk_sys) disable iff (reset)
        req_grant_q != 4'h0 |-> cpu_wait_q && ram_en_q
            && ram_addr_q == $past(req_info[win].addr))
        else $error("grant without stall or address");

    buffer_safe_a: assert property (@(posedge clk_sys) disable iff (reset)
        push && !pop |-> !(rd_valid_q && v1_q))
        else $error("read word pushed into full buffer");

    low_power_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
        (halt_mode || hold_mode) |=> req_grant_q == 4'h0)
        else $error("steal granted in low power mode");

    single_cycle_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == ST_STEAL && cpu_wait_q) |-> $onehot(req_grant_q[2:0]))
        else $error("single steal stalled without a grant");

    grant_onehot_a: assert property (@(posedge clk_sys) disable iff (reset)
        $onehot0(req_grant_q) && (!req_grant_q[0] || $past(req_valid[0])))
        else $error("grant not one-hot or not requested");

endmodule

// ### wcs_cfg.svh
`ifndef WCS_CFG_SVH
`define WCS_CFG_SVH

// Requester slots, lowest index has the highest priority
`define WCS_SRC_SER0 2'h0
`define WCS_SRC_SER4 2'h1
`define WCS_SRC_USB 2'h2
`define WCS_SRC_AUDIO 2'h3
`define WCS_NUM_SRC 4

// Audio words still owed after the first one of a burst
`define WCS_AUDIO_LEFT_TWO 2'h1
`define WCS_AUDIO_LEFT_THREE 2'h2

// Return buffer depth in words
`define WCS_BUF_DEPTH 3'h2

// Reset values
`define WCS_RST_ADDR 16'h0000
`define WCS_RST_BYTE 8'h00
`define WCS_RST_LEFT 2'h0

`endif

// ### wcs_pkg.sv
package wcs_pkg;

    // Widths of the RAM side
    typedef logic [15:0] wcs_addr_t;
    typedef logic [7:0] wcs_byte_t;
    typedef logic [1:0] wcs_src_t;

    // One RAM cycle asked for by a peripheral
    typedef struct packed {
        logic write;
        wcs_addr_t addr;
        wcs_byte_t wdata;
    } wcs_req_s;

    // One word read back, tagged with its requester
    typedef struct packed {
        wcs_src_t src;
        wcs_byte_t data;
    } wcs_rd_s;

    // Arbiter states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STEAL = 3'b010,
        ST_AUDIO = 3'b100
    } wcs_state_e;

endpackage

// ### wcs_engine_model.sv
`timescale 1ns/1ps

// Peripheral transfer engines: serial 0, serial 4, USB packet engine, audio
module wcs_engine_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] start,
    input wire logic [3:0] req_grant_q,
    output logic [3:0] req_valid
);
    logic [3:0] pend_q; // Words asked for and not yet granted

    // Raise on a start pulse, keep it up until the grant pulse arrives
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pend_q <= 4'h0;
        end else begin
            pend_q <= (pend_q | start) & ~req_grant_q;
        end
    end

    // Dropped in the grant cycle, so one word never earns two grants
    assign req_valid = pend_q & ~req_grant_q;
endmodule

// ### tb_wcs_cycle_stealer.sv
`timescale 1ns/1ps

// Bench for the cycle stealer: table rows first, then awkward cases
module tb_wcs_cycle_stealer import wcs_pkg::*;;
    // One row: requester, direction, burst choice, address, steal count
    typedef struct packed {
        logic [1:0] slot;
        logic wr;
        logic three;
        wcs_addr_t addr;
        logic [3:0] waits;
    } wcs_row_s;
    localparam wcs_row_s ROWS [5] = '{
        '{2'h0, 1'b0, 1'b0, 16'h0100, 4'h1}, '{2'h1, 1'b1, 1'b0, 16'h0210, 4'h1},
        '{2'h2, 1'b0, 1'b0, 16'h0320, 4'h1}, '{2'h3, 1'b0, 1'b0, 16'h0430, 4'h2},
        '{2'h3, 1'b1, 1'b1, 16'h0540, 4'h3}};
    logic clk_sys = 1'b0, reset = 1'b1, halt_mode = 1'b0, hold_mode = 1'b0;
    logic continuous_transfer_enable = 1'b1, audio_three_words = 1'b0, rd_ready = 1'b1;
    logic [3:0] start = 4'h0, req_valid, req_grant_q;
    wcs_req_s [3:0] info = '0; // Held by the bench beside each request
    logic cpu_wait_q, ram_en_q, ram_we_q, rd_valid_q;
    wcs_addr_t ram_addr_q;
    wcs_byte_t ram_wdata_q, ram_rdata = 8'h00;
    wcs_rd_s rd_word_q, rd_seen;
    wcs_addr_t g_addr;
    logic g_we; // Direction seen in the first granted cycle
    wcs_byte_t g_wdata; // Write byte seen in the first granted cycle
    wcs_rd_s exp_word; // Expected last word of a read row
    logic [15:0] g_log; // One-hot grants, oldest in the top nibble
    wcs_row_s r;
    int n_fail = 0, compares = 0, n_wait, n_en, n_rd;

    always #10 clk_sys = ~clk_sys;

    wcs_engine_model u_eng (.clk_sys(clk_sys), .reset(reset), .start(start),
        .req_grant_q(req_grant_q), .req_valid(req_valid));
    wcs_cycle_stealer DUT (.clk_sys(clk_sys), .reset(reset), .halt_mode(halt_mode),
        .hold_mode(hold_mode), .continuous_transfer_enable(continuous_transfer_enable),
        .audio_three_words(audio_three_words), .req_valid(req_valid), .req_info(info),
        .req_grant_q(req_grant_q), .cpu_wait_q(cpu_wait_q), .ram_en_q(ram_en_q),
        .ram_we_q(ram_we_q), .ram_addr_q(ram_addr_q), .ram_wdata_q(ram_wdata_q),
        .ram_rdata(ram_rdata), .rd_valid_q(rd_valid_q), .rd_word_q(rd_word_q),
        .rd_ready(rd_ready));

    // Sync RAM: data the cycle after a read strobe, a moving pattern otherwise
    always_ff @(posedge clk_sys) begin
        ram_rdata <= (ram_en_q && !ram_we_q) ? (ram_addr_q[7:0] ^ 8'h5A) : ~ram_rdata;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One-cycle start pulse to the engines, driven on falling edges
    task automatic go(input logic [3:0] m);
        @(negedge clk_sys);
        start = m;
        @(negedge clk_sys);
        start = 4'h0;
    endtask

    // Bounded look at the ports, sampled where outputs have settled
    task automatic watch(input int cyc);
        n_wait = 0;
        n_en = 0;
        n_rd = 0;
        g_log = 16'h0;
        repeat (cyc) begin
            @(negedge clk_sys);
            if (cpu_wait_q === 1'b1) n_wait++;
            if (ram_en_q === 1'b1) n_en++;
            if (req_grant_q !== 4'h0) begin
                if (g_log === 16'h0) begin
                    g_addr = ram_addr_q;
                    g_we = ram_we_q;
                    g_wdata = ram_wdata_q;
                end
                g_log = {g_log[11:0], req_grant_q};
            end
            if (rd_valid_q === 1'b1 && rd_ready) begin
                rd_seen = rd_word_q;
                n_rd++;
            end
        end
    endtask

    // Hang guard, well past the whole sequence
    initial begin
        repeat (50000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        check("idle outputs", {req_grant_q, cpu_wait_q, ram_en_q, rd_valid_q, rd_word_q}, 0);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            audio_three_words = r.three;
            info[r.slot] = '{r.wr, r.addr, 8'hC3};
            go(4'h1 << r.slot);
            watch(12);
            check("wait cycles", n_wait, r.waits);
            check("ram strobes", n_en, r.waits);
            check("grant slot", g_log, 16'h1 << r.slot);
            check("first addr", g_addr, r.addr);
            check("read words", n_rd, r.wr ? 0 : r.waits);
            check("direction", g_we, r.wr);
            if (r.wr) check("write byte", g_wdata, 8'hC3);
            exp_word = {r.slot, (r.addr[7:0] + {4'h0, r.waits} - 8'h1) ^ 8'h5A};
            if (!r.wr) check("last word", rd_seen, exp_word);
        end
        // Serial 0 is ignored until continuous transfer is enabled
        continuous_transfer_enable = 1'b0;
        info[0] = '{1'b0, 16'h0600, 8'h00};
        go(4'h1);
        watch(10);
        check("serial0 off", n_en, 0);
        continuous_transfer_enable = 1'b1;
        watch(10);
        check("serial0 held", n_en, 1);
        // Halt and deep standby each block steals until woken
        for (int m = 0; m < 2; m++) begin
            halt_mode = (m == 0);
            hold_mode = (m == 1);
            go(4'h2);
            watch(10);
            check("low power", n_en, 0);
            halt_mode = 1'b0;
            hold_mode = 1'b0;
            watch(10);
            check("after wake", n_en, 1);
        end
        // All four at once: fixed order, audio burst last
        foreach (info[i]) info[i] = '{1'b1, 16'h0700, 8'hA5};
        audio_three_words = 1'b0;
        go(4'hF);
        watch(16);
        check("grant order", g_log, 16'h1248);
        check("wait total", n_wait, 5);
        // Stalled reader: buffer room throttles grants, nothing is lost
        rd_ready = 1'b0;
        foreach (info[i]) info[i] = '{1'b0, 16'h0810, 8'h00};
        go(4'h7);
        watch(12);
        check("stalled reads", n_en, 2);
        check("head held", rd_valid_q, 1);
        check("head word", rd_word_q, {2'h0, 8'h10 ^ 8'h5A});
        rd_ready = 1'b1;
        watch(12);
        check("late read", n_en, 1);
        // The head word drains at the first edge, before watch looks
        check("words out", n_rd, 2);
        check("last owner", rd_seen, {2'h2, 8'h10 ^ 8'h5A});
        check("drained", rd_valid_q, 0);
        // Reset in mid-burst clears the port at once and leaves nothing owed
        go(4'h8);
        @(negedge clk_sys);
        check("burst running", cpu_wait_q, 1);
        reset = 1'b1;
        #1;
        check("reset clears", {req_grant_q, cpu_wait_q, ram_en_q, rd_valid_q}, 0);
        @(negedge clk_sys);
        reset = 1'b0;
        watch(6);
        check("no leftover", n_en, 0);
        check("no stall", n_wait, 0);
        tally_and_finish();
    end
endmodule
